// ==== hdl/ctp_pkg.sv ====
package ctp_pkg;
	// byte addresses of the byte-wide registers, one per word
	localparam logic [7:0] ADR_CTRL0 = 8'h00;
	localparam logic [7:0] ADR_CTRL1 = 8'h04;
	localparam logic [7:0] ADR_CNT_LO = 8'h08;
	localparam logic [7:0] ADR_CNT_HI = 8'h0c;
	localparam logic [7:0] ADR_CMP_LO = 8'h10;
	localparam logic [7:0] ADR_CMP_HI = 8'h14;
	localparam logic [7:0] ADR_STAT = 8'h18;
	// control zero fields
	localparam int C0_PAUSE = 7;
	localparam int C0_CK_HI = 6;
	localparam int C0_CK_LO = 4;
	localparam int C0_ON = 3;
	localparam int C0_RP_HI = 2;
	localparam int C0_RP_LO = 0;
	// control one fields
	localparam int C1_MODE_HI = 7;
	localparam int C1_MODE_LO = 6;
	localparam int C1_IO_HI = 5;
	localparam int C1_IO_LO = 4;
	localparam int C1_OC = 3;
	localparam int C1_POL = 2;
	localparam int C1_SWAP = 1;
	localparam int C1_CCLR = 0;
	// status flag positions, write one to clear
	localparam int ST_FA = 0;
	localparam int ST_FP = 1;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [9:0] CNT_RST = 10'h000;
	// operating modes
	localparam logic [1:0] MODE_CMP = 2'h0;
	localparam logic [1:0] MODE_UNDEF = 2'h1;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_TMR = 2'h3;
	// output function codes, compare mode
	localparam logic [1:0] IO_NONE = 2'h0;
	localparam logic [1:0] IO_LOW = 2'h1;
	localparam logic [1:0] IO_HIGH = 2'h2;
	localparam logic [1:0] IO_TOG = 2'h3;
	// output function codes, pwm mode
	localparam logic [1:0] PWM_INACT = 2'h0;
	localparam logic [1:0] PWM_ACT = 2'h1;
	localparam logic [1:0] PWM_WAVE = 2'h2;
	// clock select codes
	localparam logic [2:0] CK_SYS4 = 3'h0;
	localparam logic [2:0] CK_SYS = 3'h1;
	localparam logic [2:0] CK_HI16 = 3'h2;
	localparam logic [2:0] CK_HI64 = 3'h3;
	localparam logic [2:0] CK_SUB0 = 3'h4;
	localparam logic [2:0] CK_SUB1 = 3'h5;
	localparam logic [2:0] CK_EXT_R = 3'h6;
	localparam logic [2:0] CK_EXT_F = 3'h7;
	// full count of the 10-bit counter, and period step
	localparam logic [10:0] FULL_COUNT = 11'h400;
	localparam logic [6:0] STEP_ZERO = 7'h00;
	// sub clock made from the system clock by division
	localparam int SYS_CLK_HZ = 100000000;
	localparam int SUB_CLK_HZ = 32768;
	localparam int SUB_DIV = SYS_CLK_HZ / SUB_CLK_HZ;
	localparam logic [11:0] SUB_LAST = 12'(SUB_DIV - 1);
endpackage : ctp_pkg

// ==== hdl/ctp_tick_if.sv ====
`timescale 1ns/1ps
// clock select out, counting tick back
interface ctp_tick_if;
	logic tick; // one-cycle count enable
	logic [2:0] sel; // selected clock source
	modport src (output tick, input sel);
	modport snk (input tick, output sel);
endinterface : ctp_tick_if

// ==== hdl/ctp_tick.sv ====
`timescale 1ns/1ps
module ctp_tick (
	input wire logic mclk, // system clock
	input wire logic resetn, // async reset, active low
	input wire logic external_clock_pin, // event pin, asynchronous
	ctp_tick_if.src tk // select in, tick out
);
	// whole state: pin synchroniser, dividers, tick
	typedef struct packed {
		logic [2:0] sync; // [0] first stage, [2] edge history
		logic [5:0] div; // free divider for /4 /16 /64
		logic [11:0] sub; // sub clock divider
		logic tick; // registered tick
		logic [2:0] lsel; // source the tick was made for
	} ctp_tick_state_t;

	ctp_tick_state_t s;
	ctp_tick_state_t next_s;

	////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		next_s = s;
		// first stage only feeds the second stage
		next_s.sync = {s.sync[1:0], external_clock_pin};
		next_s.div = s.div + 6'h01;
		next_s.lsel = tk.sel;
		next_s.sub = (s.sub == ctp_pkg::SUB_LAST) ? 12'h000 :
			s.sub + 12'h001;
		// every code is legal, so no default branch
		unique case (tk.sel)
			ctp_pkg::CK_SYS4: next_s.tick = &s.div[1:0];
			ctp_pkg::CK_SYS: next_s.tick = 1'b1;
			ctp_pkg::CK_HI16: next_s.tick = &s.div[3:0];
			ctp_pkg::CK_HI64: next_s.tick = &s.div[5:0];
			ctp_pkg::CK_SUB0,
			ctp_pkg::CK_SUB1: next_s.tick = (s.sub == ctp_pkg::SUB_LAST);
			// edge seen on synchronised stages only
			ctp_pkg::CK_EXT_R: next_s.tick = s.sync[1] & ~s.sync[2];
			ctp_pkg::CK_EXT_F: next_s.tick = ~s.sync[1] & s.sync[2];
		endcase
	end

	////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// a tick made for a source no longer selected is dropped, so a
	// select change never lends one stale count to the new source
	assign tk.tick = s.tick & (s.lsel == tk.sel);

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	// a synchronised rising pin edge yields a tick next cycle
	AST_EXT_RISE: assert property (
		(tk.sel == ctp_pkg::CK_EXT_R) && $rose(s.sync[1])
		##1 (tk.sel == ctp_pkg::CK_EXT_R) |-> tk.tick)
		else $error("external rising edge gave no tick");
endmodule : ctp_tick

// ==== hdl/ctp_timer.sv ====
`timescale 1ns/1ps
module ctp_timer (
	input wire logic mclk, // system clock, 100 MHz
	input wire logic resetn, // async reset, active low
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write enable
	input wire logic [7:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	input wire logic external_clock_pin, // event clock pin
	output logic timer_output_pin, // primary output
	output logic inverted_output_pin, // complementary output
	output logic timer_irq // one-cycle interrupt request
);
	// whole state of the timer
	typedef struct packed {
		logic [7:0] c0; // control zero
		logic [7:0] c1; // control one
		logic [9:0] cnt; // counter
		logic [9:0] cmp; // compare value
		logic [7:0] hold; // shared low byte buffer
		logic fa; // compare match flag
		logic fp; // period match flag
		logic lvl; // compare-mode output level
		logic pin; // primary pin
		logic pinb; // complementary pin
		logic irq; // interrupt pulse
		logic ack; // bus acknowledge
		logic [7:0] dat; // read data
	} ctp_state_t;

	ctp_state_t s;
	ctp_state_t next_s;

	////////////////////////////////////////////////////////////////
	// clock source
	ctp_tick_if tk ();

	// select comes from a flop, tick back from a flop
	assign tk.sel = s.c0[ctp_pkg::C0_CK_HI:ctp_pkg::C0_CK_LO];

	ctp_tick u_tick (
		.mclk(mclk),
		.resetn(resetn),
		.external_clock_pin(external_clock_pin),
		.tk(tk)
	);

	////////////////////////////////////////////////////////////////
	// field decode
	logic on; // counter on bit
	logic pause; // pause bit
	logic [2:0] period; // period field
	logic [1:0] mode; // mode field
	logic [1:0] io; // output function field
	logic oc; // output control bit
	logic pol; // polarity bit
	logic swap; // period/duty swap bit
	logic cclr; // clear select bit

	assign on = s.c0[ctp_pkg::C0_ON];
	assign pause = s.c0[ctp_pkg::C0_PAUSE];
	assign period = s.c0[ctp_pkg::C0_RP_HI:ctp_pkg::C0_RP_LO];
	assign mode = s.c1[ctp_pkg::C1_MODE_HI:ctp_pkg::C1_MODE_LO];
	assign io = s.c1[ctp_pkg::C1_IO_HI:ctp_pkg::C1_IO_LO];
	assign oc = s.c1[ctp_pkg::C1_OC];
	assign pol = s.c1[ctp_pkg::C1_POL];
	assign swap = s.c1[ctp_pkg::C1_SWAP];
	assign cclr = s.c1[ctp_pkg::C1_CCLR];

	////////////////////////////////////////////////////////////////
	// bus decode
	logic take; // request taken this cycle
	logic wr; // low lane write
	logic rd; // read
	logic on_rise; // counter on bit goes low to high

	// one answer per request, then ack drops a cycle
	assign take = wb_cyc_i & wb_stb_i & ~s.ack;
	assign wr = take & wb_we_i & wb_sel_i[0];
	assign rd = take & ~wb_we_i;
	assign on_rise = wr && (wb_adr_i == ctp_pkg::ADR_CTRL0) &&
		wb_dat_i[ctp_pkg::C0_ON] && !on;

	////////////////////////////////////////////////////////////////
	// comparators, all on an 11-bit scale so 1024 fits
	logic [10:0] per11; // period value in clocks
	logic [10:0] cmp11; // compare as a pwm period
	logic [10:0] pv11; // pwm period
	logic [10:0] dv11; // pwm duty
	logic [10:0] nxt11; // count plus one
	logic step; // counter advances this cycle
	logic hit_a; // compare match on next count
	logic hit_p; // period match on next count
	logic clr; // hardware clear on this step

	// zero period stands for the full 1024 count
	assign per11 = (period == 3'h0) ? ctp_pkg::FULL_COUNT :
		{1'b0, period, ctp_pkg::STEP_ZERO};
	assign cmp11 = (s.cmp == 10'h000) ? ctp_pkg::FULL_COUNT :
		{1'b0, s.cmp};
	assign pv11 = swap ? cmp11 : per11;
	assign dv11 = swap ? per11 : {1'b0, s.cmp};
	assign nxt11 = {1'b0, s.cnt} + 11'h001;
	assign step = tk.tick & on & ~pause;
	// compare of zero never matches, the count overflows
	assign hit_a = (s.cmp != 10'h000) && (nxt11 == {1'b0, s.cmp});
	assign hit_p = (nxt11 == per11);

	// clear source by mode and clear select
	always_comb begin
		if (mode == ctp_pkg::MODE_PWM) begin
			clr = (nxt11 == pv11);
		end else if (cclr) begin
			clr = hit_a | (nxt11 == ctp_pkg::FULL_COUNT);
		end else begin
			clr = hit_p;
		end
	end

	////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		next_s = s;
		next_s.ack = take;
		next_s.dat = 8'h00;
		next_s.irq = step & clr;

		// control and compare writes
		if (wr) begin
			unique case (wb_adr_i)
				ctp_pkg::ADR_CTRL0: begin
					next_s.c0 = wb_dat_i[7:0];
				end
				// mode changes are only safe while off
				ctp_pkg::ADR_CTRL1: begin
					next_s.c1 = wb_dat_i[7:0];
				end
				ctp_pkg::ADR_CMP_LO: begin
					next_s.hold = wb_dat_i[7:0];
				end
				ctp_pkg::ADR_CMP_HI: begin
					next_s.cmp = {wb_dat_i[1:0], s.hold};
				end
				default: begin
					// count and unmapped writes are ignored
					next_s.hold = s.hold;
				end
			endcase
		end

		// reads, high byte loads the shared buffer
		if (rd) begin
			unique case (wb_adr_i)
				ctp_pkg::ADR_CTRL0: next_s.dat = s.c0;
				ctp_pkg::ADR_CTRL1: next_s.dat = s.c1;
				ctp_pkg::ADR_CNT_LO,
				ctp_pkg::ADR_CMP_LO: next_s.dat = s.hold;
				ctp_pkg::ADR_CNT_HI: begin
					next_s.dat = {6'h00, s.cnt[9:8]};
					next_s.hold = s.cnt[7:0];
				end
				ctp_pkg::ADR_CMP_HI: begin
					next_s.dat = {6'h00, s.cmp[9:8]};
					next_s.hold = s.cmp[7:0];
				end
				ctp_pkg::ADR_STAT: next_s.dat = {6'h00, s.fp, s.fa};
				default: next_s.dat = 8'h00;
			endcase
		end

		// counter: on-rise clears, else count or clear
		if (on_rise) begin
			next_s.cnt = ctp_pkg::CNT_RST;
		end else if (step) begin
			next_s.cnt = clr ? ctp_pkg::CNT_RST : nxt11[9:0];
		end

		// flags: a new event wins over a clear
		if (wr && (wb_adr_i == ctp_pkg::ADR_STAT)) begin
			next_s.fa = s.fa & ~wb_dat_i[ctp_pkg::ST_FA];
			next_s.fp = s.fp & ~wb_dat_i[ctp_pkg::ST_FP];
		end
		if (step && hit_a) begin
			next_s.fa = 1'b1;
		end
		// compare clear suppresses the period flag outside pwm mode
		if (step && hit_p && ((mode == ctp_pkg::MODE_PWM) || !cclr)) begin
			next_s.fp = 1'b1;
		end

		// compare-mode level: initial on rise, then matches
		if (on_rise && (mode != ctp_pkg::MODE_TMR)) begin
			next_s.lvl = s.c1[ctp_pkg::C1_OC];
		end else if (step && hit_a && (mode == ctp_pkg::MODE_CMP)) begin
			unique case (io)
				ctp_pkg::IO_NONE: next_s.lvl = s.lvl;
				ctp_pkg::IO_LOW: next_s.lvl = 1'b0;
				ctp_pkg::IO_HIGH: next_s.lvl = 1'b1;
				ctp_pkg::IO_TOG: next_s.lvl = ~s.lvl;
			endcase
		end

		// pin: pwm wave tracks the next count, so pin and count register together
		unique case (mode)
			ctp_pkg::MODE_PWM: begin
				unique case (io)
					ctp_pkg::PWM_INACT: next_s.pin = ~oc ^ pol;
					ctp_pkg::PWM_ACT: next_s.pin = oc ^ pol;
					// duty at or past period keeps active, even over a
					// count left above the period by a register change
					ctp_pkg::PWM_WAVE: next_s.pin =
						((({1'b0, next_s.cnt} < dv11) || (dv11 >= pv11)) ?
						oc : ~oc) ^ pol;
					default: next_s.pin = ~oc ^ pol;
				endcase
			end
			// pin unused; level kept, polarity ignored
			ctp_pkg::MODE_TMR: next_s.pin = s.pin;
			default: next_s.pin = next_s.lvl ^ pol;
		endcase
		next_s.pinb = ~next_s.pin;
	end

	////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs straight from flops
	assign wb_dat_o = {24'h000000, s.dat};
	assign wb_ack_o = s.ack;
	assign timer_output_pin = s.pin;
	assign inverted_output_pin = s.pinb;
	assign timer_irq = s.irq;

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	sequence s_wr_lo;
		wr && (wb_adr_i == ctp_pkg::ADR_CMP_LO);
	endsequence

	sequence s_wr_hi;
		wr && (wb_adr_i == ctp_pkg::ADR_CMP_HI);
	endsequence

	sequence s_period_step;
		step && hit_p && (mode != ctp_pkg::MODE_PWM) && !cclr && !on_rise;
	endsequence

	AST_ON_CLEAR: assert property (
		on_rise |=> (s.cnt == 10'h000) && on)
		else $error("on rise did not clear the count");

	AST_OFF_HOLD: assert property (
		!on && !on_rise |=> $stable(s.cnt))
		else $error("count moved while off");

	AST_PAUSE_HOLD: assert property (
		pause && !on_rise |=> $stable(s.cnt))
		else $error("count moved while paused");

	AST_COUNT_UP: assert property (
		step && !clr && !on_rise |=> s.cnt == $past(s.cnt) + 10'h001)
		else $error("count did not advance by one");

	AST_PERIOD_CLEAR: assert property (
		s_period_step |=> (s.cnt == 10'h000) && s.fp && timer_irq)
		else $error("period match did not clear and flag");

	AST_NO_PFLAG: assert property (
		(mode != ctp_pkg::MODE_PWM) && cclr && !s.fp |=> !s.fp)
		else $error("period flag set under compare clear");

	AST_HOLD_BUF: assert property (
		s_wr_lo |=> $stable(s.cmp) && (s.hold == $past(wb_dat_i[7:0])))
		else $error("low write reached compare directly");

	// the high write commits the buffer beside its own two bits
	AST_CMP_COMMIT: assert property (
		s_wr_hi |=> s.cmp == {$past(wb_dat_i[1:0]), $past(s.hold)})
		else $error("high write did not commit the pair");

	AST_INIT_LVL: assert property (
		on_rise && (mode == ctp_pkg::MODE_CMP)
		|=> timer_output_pin == ($past(oc) ^ $past(pol)))
		else $error("output not at initial level after on rise");

	AST_FULL_DUTY: assert property (
		(mode == ctp_pkg::MODE_PWM) && (io == ctp_pkg::PWM_WAVE) &&
		(dv11 >= pv11) && !wr |=> timer_output_pin == ($past(oc) ^ $past(pol)))
		else $error("full duty not held active");

	AST_BUS_ACK: assert property (
		take |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single cycle");

	AST_MATCH_LOW: assert property (
		step && hit_a && (mode == ctp_pkg::MODE_CMP) &&
		(io == ctp_pkg::IO_LOW) && !on_rise
		|=> timer_output_pin == $past(pol))
		else $error("low-on-match output not low");

	// timer mode leaves the pin where it was
	AST_TMR_PIN: assert property (
		mode == ctp_pkg::MODE_TMR |=> $stable(timer_output_pin))
		else $error("pin moved in timer mode");

	// a request always comes with the count back at zero
	AST_IRQ_CLEAR: assert property (
		timer_irq |-> s.cnt == 10'h000)
		else $error("request without a cleared count");
endmodule : ctp_timer

// ==== testbench/ctp_far_end.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// far side: event clock source and the load on both output pins
module ctp_far_end (
	input wire logic mclk, // system clock
	input wire logic timer_output_pin, // watched primary pin
	input wire logic inverted_output_pin, // watched complement pin
	output logic external_clock_pin // event source
);
	// a driven source rests low between bursts
	initial begin
		external_clock_pin = 1'b0;
	end
	// n whole pulses; each level held long enough for the synchroniser
	task automatic send(input int n);
		repeat (n) begin
			@(posedge mclk);
			external_clock_pin <= 1'b1;
			repeat (5) @(posedge mclk);
			external_clock_pin <= 1'b0;
			repeat (4) @(posedge mclk);
		end
	endtask : send
	// cycles high on the pin, and cycles low on its complement
	task automatic measure(input int n, output int h, output int b);
		h = 0;
		b = 0;
		repeat (n) begin
			@(posedge mclk);
			h += int'(timer_output_pin === 1'b1);
			b += int'(inverted_output_pin === 1'b0);
		end
	endtask : measure
endmodule : ctp_far_end

// ==== testbench/ctp_timer_tb_top.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// top bench: register table rows, then counting, pin and pwm cases
module ctp_timer_tb_top;
	// one bus step: direction, address, data, expected read
	typedef struct {
		logic we;
		logic [7:0] a;
		logic [7:0] d;
		logic [31:0] e;
	} ctp_row_t;
	logic mclk; // system clock
	logic resetn; // reset, active low
	logic cyc; // bus cycle
	logic stb; // strobe
	logic we; // write enable
	logic [7:0] adr; // byte address
	logic [3:0] sel; // byte lanes
	logic [31:0] wdat; // write data
	logic [31:0] rdat; // read data
	logic ack; // acknowledge
	logic ext; // event clock pin
	logic tpin; // primary output
	logic ipin; // complement output
	logic irq; // interrupt request
	logic [31:0] q; // last read value
	int err_count; // mismatches
	int num_checks; // comparisons
	int c; // cycles between clears
	int h; // high cycles seen
	int b; // low cycles of complement
	// reset values, buffered compare pair, read-only count, hole
	ctp_row_t rows [19] = '{
		'{1'b0, ctp_pkg::ADR_CTRL0, 8'h00, 32'h0},
		'{1'b0, ctp_pkg::ADR_CTRL1, 8'h00, 32'h0},
		'{1'b0, ctp_pkg::ADR_CNT_LO, 8'h00, 32'h0},
		'{1'b0, ctp_pkg::ADR_CNT_HI, 8'h00, 32'h0},
		'{1'b0, ctp_pkg::ADR_CMP_HI, 8'h00, 32'h0},
		'{1'b0, ctp_pkg::ADR_CMP_LO, 8'h00, 32'h0},
		'{1'b1, ctp_pkg::ADR_CTRL1, 8'hab, 32'h0},
		'{1'b0, ctp_pkg::ADR_CTRL1, 8'h00, 32'hab},
		'{1'b1, ctp_pkg::ADR_CMP_LO, 8'h5a, 32'h0},
		'{1'b0, ctp_pkg::ADR_CMP_HI, 8'h00, 32'h0},
		'{1'b0, ctp_pkg::ADR_CMP_LO, 8'h00, 32'h0},
		'{1'b1, ctp_pkg::ADR_CMP_LO, 8'h5a, 32'h0},
		'{1'b1, ctp_pkg::ADR_CMP_HI, 8'hff, 32'h0},
		'{1'b0, ctp_pkg::ADR_CMP_HI, 8'h00, 32'h3},
		'{1'b0, ctp_pkg::ADR_CMP_LO, 8'h00, 32'h5a},
		'{1'b1, ctp_pkg::ADR_CNT_LO, 8'h77, 32'h0},
		'{1'b0, ctp_pkg::ADR_CNT_HI, 8'h00, 32'h0},
		'{1'b0, ctp_pkg::ADR_CNT_LO, 8'h00, 32'h0},
		'{1'b0, 8'h1c, 8'h00, 32'h0}
	};
	// control zero settings and clocks between clears
	logic [7:0] pc [4] = '{8'h19, 8'h1f, 8'h18, 8'h09};
	int pw [4] = '{128, 896, 1024, 512};
	// compare mode control one; pin level before and after a match
	logic [7:0] ic [4] = '{8'h09, 8'h19, 8'h21, 8'h39};
	logic [1:0] iv [4] = '{2'h3, 2'h2, 2'h1, 2'h2};
	// pwm control one and high cycles per 128
	logic [7:0] pm [6] = '{8'ha8, 8'haa, 8'h88, 8'h98, 8'ha0, 8'hac};
	int ph [6] = '{32, 128, 0, 128, 96, 96};
	// event clock steps: control zero and count after five pulses
	logic [7:0] xc [5] = '{8'h68, 8'he8, 8'h68, 8'h60, 8'h78};
	logic [31:0] xq [5] = '{32'h5, 32'h5, 32'ha, 32'ha, 32'h5};
	// clock sources under a compare of one: cycles per tick
	logic [7:0] kc [6] = '{8'h08, 8'h18, 8'h28, 8'h38, 8'h48, 8'h58};
	int kw [6] = '{4, 1, 16, 64, ctp_pkg::SUB_DIV, ctp_pkg::SUB_DIV};

	ctp_timer dut (
		.mclk(mclk), // clock
		.resetn(resetn), // reset
		.wb_cyc_i(cyc), // cycle
		.wb_stb_i(stb), // strobe
		.wb_we_i(we), // direction
		.wb_adr_i(adr), // address
		.wb_sel_i(sel), // lanes
		.wb_dat_i(wdat), // write data
		.wb_dat_o(rdat), // read data
		.wb_ack_o(ack), // acknowledge
		.external_clock_pin(ext), // event pin
		.timer_output_pin(tpin), // primary
		.inverted_output_pin(ipin), // complement
		.timer_irq(irq) // request
	);
	ctp_far_end far (
		.mclk(mclk), // clock
		.timer_output_pin(tpin), // load
		.inverted_output_pin(ipin), // load
		.external_clock_pin(ext) // source
	);

	////////////////////////////////////////////////////////////////////
	// 100 MHz clock
	initial mclk = 1'b0;
	always #5 mclk = ~mclk;

	// verdict and end of run
	task automatic conclude();
		if (err_count == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk
	// classic cycle, held until ack, then released for a cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h000000, d};
		do begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) begin
			err_count++;
			conclude();
		end
		@(posedge mclk);
	endtask : wb
	// cycles up to the next request pulse, bounded
	task automatic wait_irq(output int n);
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (irq !== 1'b1 && n < 4000);
		if (n >= 4000) begin
			err_count++;
			conclude();
		end
	endtask : wait_irq
	// high byte first so the low byte comes through the buffer
	task automatic rdcnt();
		logic [31:0] hi;
		wb(1'b0, ctp_pkg::ADR_CNT_HI, 8'h00);
		hi = q;
		wb(1'b0, ctp_pkg::ADR_CNT_LO, 8'h00);
		q = {hi[23:0], q[7:0]};
	endtask : rdcnt

	////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'hf;
		wdat = 32'h0;
		err_count = 0;
		num_checks = 0;
		resetn = 1'b0;
		repeat (8) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		foreach (rows[i]) begin
			wb(rows[i].we, rows[i].a, rows[i].d);
			if (!rows[i].we) chk(q, rows[i].e);
		end
		// mode changed only while off
		wb(1'b1, ctp_pkg::ADR_CTRL0, 8'h10);
		wb(1'b1, ctp_pkg::ADR_CTRL1, 8'h00);
		foreach (pc[i]) begin
			wb(1'b1, ctp_pkg::ADR_CTRL0, 8'h10);
			wb(1'b1, ctp_pkg::ADR_CTRL0, pc[i]);
			wait_irq(c);
			wait_irq(c);
			chk(c, pw[i]);
		end
		// compare of ten, flags cleared first
		wb(1'b1, ctp_pkg::ADR_STAT, 8'h03);
		wb(1'b1, ctp_pkg::ADR_CMP_LO, 8'h0a);
		wb(1'b1, ctp_pkg::ADR_CMP_HI, 8'h00);
		foreach (ic[i]) begin
			wb(1'b1, ctp_pkg::ADR_CTRL0, 8'h10);
			wb(1'b1, ctp_pkg::ADR_CTRL1, ic[i]);
			wb(1'b1, ctp_pkg::ADR_CTRL0, 8'h18);
			chk({tpin, ipin}, {iv[i][1], ~iv[i][1]});
			wait_irq(c);
			chk({tpin, ipin}, {iv[i][0], ~iv[i][0]});
			wait_irq(c);
			chk(c, 10);
		end
		wb(1'b0, ctp_pkg::ADR_STAT, 8'h00);
		chk(q, 32'h1);
		// inverted initial level
		wb(1'b1, ctp_pkg::ADR_CTRL0, 8'h10);
		wb(1'b1, ctp_pkg::ADR_CTRL1, 8'h3d);
		wb(1'b1, ctp_pkg::ADR_CTRL0, 8'h18);
		chk({tpin, ipin}, 32'h1);
		// pwm with a compare of 32, function set only while off
		wb(1'b1, ctp_pkg::ADR_CMP_LO, 8'h20);
		wb(1'b1, ctp_pkg::ADR_CMP_HI, 8'h00);
		foreach (pm[i]) begin
			wb(1'b1, ctp_pkg::ADR_CTRL0, 8'h10);
			wb(1'b1, ctp_pkg::ADR_CTRL1, pm[i]);
			wb(1'b1, ctp_pkg::ADR_CTRL0, 8'h19);
			wait_irq(c);
			far.measure(128, h, b);
			chk(h, ph[i]);
			chk(b, ph[i]);
		end
		// timer mode on the event pin: restart, pause, resume, hold
		wb(1'b1, ctp_pkg::ADR_CTRL0, 8'h10);
		wb(1'b1, ctp_pkg::ADR_CTRL1, 8'hc0);
		foreach (xc[i]) begin
			wb(1'b1, ctp_pkg::ADR_CTRL0, xc[i]);
			far.send(5);
			repeat (20) @(posedge mclk);
			rdcnt();
			chk(q, xq[i]);
		end
		// source codes 0 to 5, no event pin: each tick clears, so irq spacing is the tick
		wb(1'b1, ctp_pkg::ADR_CTRL0, 8'h10);
		wb(1'b1, ctp_pkg::ADR_CTRL1, 8'h01);
		wb(1'b1, ctp_pkg::ADR_CMP_LO, 8'h01);
		wb(1'b1, ctp_pkg::ADR_CMP_HI, 8'h00);
		foreach (kc[i]) begin
			wb(1'b1, ctp_pkg::ADR_CTRL0, kc[i]);
			wait_irq(c);
			wait_irq(c);
			chk(c, kw[i]);
		end
		// mid-run reset: control, count, primary pin and request back to rest
		resetn <= 1'b0;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		chk({tpin, irq}, 32'h0);
		wb(1'b0, ctp_pkg::ADR_CTRL0, 8'h00);
		chk(q, {24'h0, ctp_pkg::CTRL_RST});
		rdcnt();
		chk(q, {22'h0, ctp_pkg::CNT_RST});
		conclude();
	end
endmodule : ctp_timer_tb_top
